//--- rdqm_pkg.sv
// Package for the receive descriptor queue manager
package rdqm_pkg;
    // ****************************************
    // Register map (word offsets, byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] ADDR_DESC_TABLE_BASE = 6'h00;
    localparam logic [5:0] ADDR_QUEUE_BASE = 6'h01;
    localparam logic [5:0] ADDR_LFQ_START = 6'h02;
    localparam logic [5:0] ADDR_LFQ_WRITE = 6'h03;
    localparam logic [5:0] ADDR_LFQ_READ = 6'h04;
    localparam logic [5:0] ADDR_LFQ_END = 6'h05;
    localparam logic [5:0] ADDR_RQ_START = 6'h06;
    localparam logic [5:0] ADDR_RQ_WRITE = 6'h07;
    localparam logic [5:0] ADDR_RQ_READ = 6'h08;
    localparam logic [5:0] ADDR_RQ_END = 6'h09;
    localparam logic [5:0] ADDR_SFQ_START = 6'h0A;
    localparam logic [5:0] ADDR_SFQ_WRITE = 6'h0B;
    localparam logic [5:0] ADDR_SFQ_READ = 6'h0C;
    localparam logic [5:0] ADDR_SFQ_END = 6'h0D;
    localparam logic [5:0] ADDR_STATUS = 6'h0E;
    localparam logic [5:0] ADDR_ERR_CLEAR = 6'h0F;
    localparam int REG_ADDR_W = 6;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int REF_W = 14;
    localparam int IDX_W = 16;
    localparam int STS_W = 2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_IDX = 16'h0000;
    localparam logic [3:0] DESC_BASE_LOW_ZERO = 4'h0;
    localparam logic [1:0] QUEUE_BASE_LOW_ZERO = 2'h0;
    localparam logic [7:0] RQ_THIRD_BYTE = 8'h00;
    localparam logic [3:0] RQ_BYTE_EN = 4'h7;

    // Ready-queue status codes
    localparam logic [1:0] STS_GOOD = 2'h0;
    localparam logic [1:0] STS_FAIL = 2'h1;
    localparam logic [1:0] STS_PARTIAL = 2'h2;

    // Queue selector: large free, ready, small free
    typedef enum logic [1:0] {
        RDQM_Q_LARGE = 2'b00,
        RDQM_Q_READY = 2'b01,
        RDQM_Q_SMALL = 2'b10
    } rdqm_queue_t;

    typedef enum logic [3:0] {
        RDQM_IDLE = 4'b0000,
        RDQM_PICK = 4'b0001,
        RDQM_FETCH = 4'b0010,
        RDQM_FETCH_W = 4'b0011,
        RDQM_LINK = 4'b0100,
        RDQM_LINK_W = 4'b0101,
        RDQM_POST = 4'b0110,
        RDQM_POST_W = 4'b0111,
        RDQM_WAIT = 4'b1000
    } rdqm_state_t;
endpackage

//--- rdqm_top.sv
// Receive descriptor queue manager: free/ready queues and chain building
// Operation
// - Descriptors addressed by 14-bit reference, up to 16384 entries.
// - Descriptor address is table base bits 31:4 plus reference.
// - Large free, small free and ready queues live in host memory.
// - Fetch free references when needed; post only after whole packet.
// - First buffer is small, remainder large, all linked in a chain.
// - Four 16-bit indices per queue; entry address is base plus 4*index.
// - Remover advances read index, adder advances write index.
// - Read is last consumed, write next free; end never holds entry.
// - Empty when read is write-1, or read is end-1 with write at start.
// - Full when read equals write; nothing more may be added.
// - Status 00 good, 01 failed, 10 partial; never produce 11.
// - Needed size empty: take a reference from the other free queue.
// - Both free queues empty when a buffer is needed: raise error.
// - Ready entry: status in 15:14, first reference in 13:0.
// - Extend chain with large buffers; post first reference only.
// - Ready entry write zeroes third byte, leaves top byte unchanged.
// - Link descriptors through 14-bit next field while chain-end clear.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rdqm_top
    import rdqm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [rdqm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Buffer requests from the packet side
    input wire logic buf_req,
    input wire logic pkt_start,
    output logic buf_ack,
    output logic [rdqm_pkg::REF_W-1:0] buf_ref,
    output logic [31:0] buf_desc_addr,
    // Packet completion
    input wire logic pkt_done,
    input wire logic [rdqm_pkg::STS_W-1:0] pkt_status,
    output logic pkt_done_ack,
    // Host memory master
    output logic mem_req,
    output logic mem_we,
    output logic [3:0] mem_be,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Error
    output logic queue_error_interrupt
);
    import rdqm_pkg::*;

    // ****************************************
    // Queue index helpers
    // ****************************************
    // wrap to start when stepping onto end
    function automatic logic [15:0] idx_next(input logic [15:0] idx,
        input logic [15:0] s, input logic [15:0] e);
        logic [15:0] n;
        n = idx + 16'h0001;
        idx_next = (n == e) ? s : n;
    endfunction

    function automatic logic q_empty(input logic [15:0] r,
        input logic [15:0] w, input logic [15:0] s, input logic [15:0] e);
        q_empty = (r == w - 16'h0001) ||
                  ((r == e - 16'h0001) && (w == s)) ||
                  (s == e);
    endfunction

    function automatic logic [31:0] q_addr(input logic [31:0] base,
        input logic [15:0] idx);
        q_addr = base + {14'h0000, idx, 2'h0};
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] desc_table_base_q;
    logic [31:0] queue_base_q;
    logic [15:0] q_start_q [3];
    logic [15:0] q_write_q [3];
    logic [15:0] q_read_q [3];
    logic [15:0] q_end_q [3];
    logic err_q;

    rdqm_state_t state_q;
    rdqm_queue_t sel_q;
    logic want_small_q;
    logic [REF_W-1:0] first_ref_q;
    logic [REF_W-1:0] prev_ref_q;
    logic [REF_W-1:0] new_ref_q;
    logic [STS_W-1:0] status_q;
    logic chained_q;

    logic sfq_empty;
    logic lfq_empty;
    logic rq_full;
    logic [15:0] next_read;
    logic [15:0] rq_next_write;
    logic eng_read_adv;
    logic eng_write_adv;

    assign sfq_empty = q_empty(q_read_q[RDQM_Q_SMALL],
        q_write_q[RDQM_Q_SMALL], q_start_q[RDQM_Q_SMALL],
        q_end_q[RDQM_Q_SMALL]);
    assign lfq_empty = q_empty(q_read_q[RDQM_Q_LARGE],
        q_write_q[RDQM_Q_LARGE], q_start_q[RDQM_Q_LARGE],
        q_end_q[RDQM_Q_LARGE]);
    assign rq_full = (q_read_q[RDQM_Q_READY] == q_write_q[RDQM_Q_READY]);
    // read marks last consumed, so next entry is one past it
    assign next_read = idx_next(q_read_q[sel_q], q_start_q[sel_q],
        q_end_q[sel_q]);
    assign rq_next_write = idx_next(q_write_q[RDQM_Q_READY],
        q_start_q[RDQM_Q_READY], q_end_q[RDQM_Q_READY]);
    assign eng_read_adv = (state_q == RDQM_FETCH_W) && mem_ack;
    assign eng_write_adv = (state_q == RDQM_POST_W) && mem_ack;

    // ****************************************
    // Register writes
    // ****************************************
    // Host set-up before reception host moves its own ends
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            desc_table_base_q <= RST_WORD;
            queue_base_q <= RST_WORD;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_DESC_TABLE_BASE) begin
                desc_table_base_q <= {reg_wdata[31:4], DESC_BASE_LOW_ZERO};
            end
            if (reg_addr == ADDR_QUEUE_BASE) begin
                queue_base_q <= {reg_wdata[31:2], QUEUE_BASE_LOW_ZERO};
            end
        end
    end

    genvar gq;
    generate
        for (gq = 0; gq < 3; gq++) begin : g_queue
            localparam logic [5:0] BASE_ADDR = ADDR_LFQ_START +
                6'(4 * gq);
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    q_start_q[gq] <= RST_IDX;
                    q_end_q[gq] <= RST_IDX;
                end else if (reg_wr) begin
                    if (reg_addr == BASE_ADDR) begin
                        q_start_q[gq] <= reg_wdata[15:0];
                    end
                    if (reg_addr == BASE_ADDR + 6'h03) begin
                        q_end_q[gq] <= reg_wdata[15:0];
                    end
                end
            end
            // Engine advance wins over a host write in the same cycle
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    q_read_q[gq] <= RST_IDX;
                end else if (eng_read_adv && (sel_q == rdqm_queue_t'(gq))) begin
                    q_read_q[gq] <= next_read;
                end else if (reg_wr && reg_addr == BASE_ADDR + 6'h02) begin
                    q_read_q[gq] <= reg_wdata[15:0];
                end
            end
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    q_write_q[gq] <= RST_IDX;
                end else if (eng_write_adv && gq == 1) begin
                    q_write_q[gq] <= rq_next_write;
                end else if (reg_wr && reg_addr == BASE_ADDR + 6'h01) begin
                    q_write_q[gq] <= reg_wdata[15:0];
                end
            end
        end
    endgenerate

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_DESC_TABLE_BASE: reg_rdata <= desc_table_base_q;
                ADDR_QUEUE_BASE: reg_rdata <= queue_base_q;
                ADDR_LFQ_START: reg_rdata <= {16'h0000, q_start_q[0]};
                ADDR_LFQ_WRITE: reg_rdata <= {16'h0000, q_write_q[0]};
                ADDR_LFQ_READ: reg_rdata <= {16'h0000, q_read_q[0]};
                ADDR_LFQ_END: reg_rdata <= {16'h0000, q_end_q[0]};
                ADDR_RQ_START: reg_rdata <= {16'h0000, q_start_q[1]};
                ADDR_RQ_WRITE: reg_rdata <= {16'h0000, q_write_q[1]};
                ADDR_RQ_READ: reg_rdata <= {16'h0000, q_read_q[1]};
                ADDR_RQ_END: reg_rdata <= {16'h0000, q_end_q[1]};
                ADDR_SFQ_START: reg_rdata <= {16'h0000, q_start_q[2]};
                ADDR_SFQ_WRITE: reg_rdata <= {16'h0000, q_write_q[2]};
                ADDR_SFQ_READ: reg_rdata <= {16'h0000, q_read_q[2]};
                ADDR_SFQ_END: reg_rdata <= {16'h0000, q_end_q[2]};
                ADDR_STATUS: reg_rdata <= {24'h000000, 1'b0,
                    rq_full, lfq_empty, sfq_empty, state_q};
                default: reg_rdata <= RST_WORD;
            endcase
        end else begin
            reg_rdata <= RST_WORD;
        end
    end

    // ****************************************
    // Engine
    // ****************************************
    // Sequence: pick queue, read reference, link it, later post first one
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= RDQM_IDLE;
            sel_q <= RDQM_Q_SMALL;
            want_small_q <= 1'b1;
            first_ref_q <= '0;
            prev_ref_q <= '0;
            new_ref_q <= '0;
            status_q <= STS_GOOD;
            chained_q <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_be <= 4'h0;
            mem_addr <= RST_WORD;
            mem_wdata <= RST_WORD;
            buf_ack <= 1'b0;
            buf_ref <= '0;
            buf_desc_addr <= RST_WORD;
            pkt_done_ack <= 1'b0;
        end else begin
            buf_ack <= 1'b0;
            pkt_done_ack <= 1'b0;
            case (state_q)
                RDQM_IDLE: begin
                    if (pkt_done && chained_q) begin
                        // Only post once the packet is complete
                        status_q <= (pkt_status == 2'h3) ? STS_FAIL :
                            pkt_status;
                        state_q <= RDQM_POST;
                    // A request still high in its grant cycle was served;
                    // taking it again would fetch a buffer nobody asked for
                    end else if (buf_req && !buf_ack) begin
                        // First buffer small, rest large
                        want_small_q <= pkt_start || !chained_q;
                        state_q <= RDQM_PICK;
                    end
                end
                RDQM_PICK: begin
                    if (sfq_empty && lfq_empty) begin
                        state_q <= RDQM_WAIT;
                    end else if (want_small_q) begin
                        sel_q <= sfq_empty ? RDQM_Q_LARGE : RDQM_Q_SMALL;
                        state_q <= RDQM_FETCH;
                    end else begin
                        sel_q <= lfq_empty ? RDQM_Q_SMALL : RDQM_Q_LARGE;
                        state_q <= RDQM_FETCH;
                    end
                end
                RDQM_FETCH: begin
                    // read the free reference from host memory
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_be <= 4'hF;
                    mem_addr <= q_addr(queue_base_q, next_read);
                    state_q <= RDQM_FETCH_W;
                end
                RDQM_FETCH_W: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        new_ref_q <= mem_rdata[REF_W-1:0];
                        state_q <= (chained_q && !want_small_q) ?
                            RDQM_LINK : RDQM_IDLE;
                        if (!chained_q || want_small_q) begin
                            first_ref_q <= mem_rdata[REF_W-1:0];
                            prev_ref_q <= mem_rdata[REF_W-1:0];
                            chained_q <= 1'b1;
                            buf_ack <= 1'b1;
                            buf_ref <= mem_rdata[REF_W-1:0];
                            buf_desc_addr <= {desc_table_base_q[31:4],
                                4'h0} + {18'h00000, mem_rdata[REF_W-1:0]};
                        end
                    end
                end
                RDQM_LINK: begin
                    // next field of previous descriptor, low bits
                    // append the large buffer to the chain
                    mem_req <= 1'b1;
                    mem_we <= 1'b1;
                    mem_be <= 4'h3;
                    mem_addr <= {desc_table_base_q[31:4], 4'h0} +
                        {18'h00000, prev_ref_q};
                    mem_wdata <= {18'h00000, new_ref_q};
                    state_q <= RDQM_LINK_W;
                end
                RDQM_LINK_W: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        prev_ref_q <= new_ref_q;
                        buf_ack <= 1'b1;
                        buf_ref <= new_ref_q;
                        buf_desc_addr <= {desc_table_base_q[31:4], 4'h0} +
                            {18'h00000, new_ref_q};
                        state_q <= RDQM_IDLE;
                    end
                end
                RDQM_POST: begin
                    // hold off while ready queue is full
                    if (!rq_full) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_be <= RQ_BYTE_EN;
                        mem_addr <= q_addr(queue_base_q,
                            q_write_q[RDQM_Q_READY]);
                        mem_wdata <= {8'h00, RQ_THIRD_BYTE, status_q,
                            first_ref_q};
                        state_q <= RDQM_POST_W;
                    end
                end
                RDQM_POST_W: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        chained_q <= 1'b0;
                        pkt_done_ack <= 1'b1;
                        state_q <= RDQM_IDLE;
                    end
                end
                RDQM_WAIT: begin
                    // Retry once the host refills a free queue
                    if (!(sfq_empty && lfq_empty)) begin
                        state_q <= RDQM_PICK;
                    end
                end
                default: state_q <= RDQM_IDLE;
            endcase
        end
    end

    // ****************************************
    // Error flag
    // ****************************************
    // Set wins over the host clear in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            err_q <= 1'b0;
        end else if (state_q == RDQM_PICK && sfq_empty && lfq_empty) begin
            err_q <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_ERR_CLEAR) begin
            err_q <= 1'b0;
        end
    end
    assign queue_error_interrupt = err_q;
endmodule
`default_nettype wire

//--- rdqm_chk.sv
// Port assertions for the receive descriptor queue manager
`timescale 1ns/1ps
`default_nettype none
module rdqm_chk
    import rdqm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [rdqm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Handshakes
    input wire logic buf_req,
    input wire logic buf_ack,
    input wire logic pkt_done,
    input wire logic pkt_done_ack,
    // Memory master
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    // Error
    input wire logic queue_error_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic post;
    assign post = mem_req && mem_we && mem_be == 4'h7;

    chk_grant_on_req: assert property (buf_ack |-> $past(buf_req))
        else $error("grant without request");
    chk_post_upper: assert property (post |-> mem_wdata[31:16] == 16'h0)
        else $error("ready entry upper bytes wrong");
    chk_status_legal: assert property (post |-> mem_wdata[15:14] != 2'h3)
        else $error("reserved status posted");
    chk_queue_aligned: assert property ((mem_req && !mem_we) || post
        |-> mem_addr[1:0] == 2'h0) else $error("queue access unaligned");
    chk_req_holds: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we))
        else $error("memory request changed before ack");
    chk_req_release: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request not released");
    chk_done_after_post: assert property (post && mem_ack
        |=> ##[0:2] pkt_done_ack) else $error("post not acknowledged");
    chk_done_cause: assert property (pkt_done_ack |-> $past(pkt_done))
        else $error("done ack without packet end");
    chk_error_sticky: assert property (queue_error_interrupt
        && !(reg_wr && reg_addr == ADDR_ERR_CLEAR) |=> queue_error_interrupt)
        else $error("error flag dropped by itself");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_write_lanes: assert property (mem_req && mem_we
        |-> mem_be == 4'h3 || mem_be == 4'h7) else $error("bad byte lanes");
endmodule
`default_nettype wire

//--- rdqm_mem.sv
// Host memory model answering the engine's memory master
`timescale 1ns/1ps
`default_nettype none
module rdqm_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Answer delay in cycles
    input wire logic [3:0] ack_delay,
    // Memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:1023];
    logic [3:0] wait_q;
    // Plain always: the bench preloads queues directly
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        // Stale data must not look valid after the ack
        if (mem_ack) mem_rdata <= ~mem_rdata;
        if (!reset_n) begin
            wait_q <= 4'h0;
            mem_rdata <= 32'h5A5A_A5A5;
        end else if (mem_req && !mem_ack) begin
            if (wait_q >= ack_delay) begin
                mem_ack <= 1'b1;
                wait_q <= 4'h0;
                mem_rdata <= mem[mem_addr[11:2]];
                for (int b = 0; b < 4; b++) begin
                    if (mem_we && mem_be[b]) begin
                        mem[mem_addr[11:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
                    end
                end
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
// Testbench for the receive descriptor queue manager
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rdqm_pkg::*;
    localparam int LIM = 300;
    localparam logic [31:0] TBL = 32'h0000_0800;
    logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata;
    logic buf_req = 1'b0, pkt_start = 1'b0, pkt_done = 1'b0;
    logic [1:0] pkt_status = 2'h0;
    logic buf_ack, pkt_done_ack, mem_req, mem_we, mem_ack;
    logic queue_error_interrupt;
    logic [13:0] buf_ref;
    logic [31:0] buf_desc_addr;
    logic [3:0] mem_be, ack_delay = 4'h0;
    int num_errors = 0, checks_done = 0;
    // Queues sit back to back: small, large, ready
    logic [31:0] cfg [14] = '{TBL, 32'h100, 32'h15, 32'h16, 32'h18, 32'h19,
        32'h19, 32'h19, 32'h1C, 32'h1D, 32'h10, 32'h13, 32'h14, 32'h15};

    always #20 clk = ~clk;

    rdqm_top i_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .buf_req, .pkt_start, .buf_ack, .buf_ref, .buf_desc_addr,
        .pkt_done, .pkt_status, .pkt_done_ack, .mem_req, .mem_we, .mem_be,
        .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .queue_error_interrupt);
    rdqm_mem i_mem (.clk, .reset_n, .ack_delay, .mem_req, .mem_we, .mem_be,
        .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp);
    endtask
    task automatic wait_buf(input logic [13:0] r);
        int n = 0;
        do begin @(posedge clk); n++; end while (buf_ack !== 1'b1 && n < LIM);
        if (buf_ack !== 1'b1) begin num_errors++; final_report(); end
        buf_req <= 1'b0;
        pkt_start <= 1'b0;
        check({18'h0, buf_ref}, {18'h0, r});
        check(buf_desc_addr, TBL + {18'h0, r});
    endtask
    task automatic get_buf(input logic s, input logic [13:0] r);
        @(posedge clk);
        buf_req <= 1'b1;
        pkt_start <= s;
        wait_buf(r);
    endtask
    task automatic finish(input logic [1:0] st, input logic [13:0] r,
        input logic [9:0] w, input logic stall);
        int n = 0;
        logic hit = 1'b0;
        @(posedge clk);
        pkt_done <= 1'b1;
        pkt_status <= st;
        if (stall) begin
            repeat (40) begin @(posedge clk); hit |= pkt_done_ack; end
            check(hit, 1'b0);
            wr(ADDR_RQ_READ, 32'h19);
        end
        do begin @(posedge clk); n++; end while (pkt_done_ack !== 1'b1 && n < LIM);
        if (pkt_done_ack !== 1'b1) begin num_errors++; final_report(); end
        pkt_done <= 1'b0;
        repeat (2) @(posedge clk);
        check(i_mem.mem[w], {8'hAA, 8'h00, st, r});
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int n;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 14; i++) rd_chk(6'(i), 32'h0);
        for (int i = 0; i < 14; i++) wr(6'(i), 32'hFFFF_FFFF);
        for (int i = 0; i < 14; i++) rd_chk(6'(i), i == 0 ? 32'hFFFF_FFF0 :
            i == 1 ? 32'hFFFF_FFFC : 32'h0000_FFFF);
        wr(6'h3F, 32'h1234_5678);
        rd_chk(6'h3F, 32'h0);
        for (int i = 0; i < 3; i++) i_mem.mem[10'h50 + i] = 32'h101 + i;
        i_mem.mem[10'h55] = 32'h201;
        for (int i = 0; i < 4; i++) i_mem.mem[10'h59 + i] = 32'hAA55_FFFF;
        for (int i = 0; i < 14; i++) wr(6'(i), cfg[i]);
        get_buf(1'b1, 14'h101);
        get_buf(1'b0, 14'h201);
        check({16'h0, i_mem.mem[10'h240][15:0]}, 32'h201);
        finish(STS_FAIL, 14'h101, 10'h59, 1'b0);
        rd_chk(ADDR_SFQ_READ, 32'h10);
        rd_chk(ADDR_LFQ_READ, 32'h15);
        rd_chk(ADDR_RQ_WRITE, 32'h1A);
        ack_delay <= 4'h3;
        get_buf(1'b1, 14'h102);
        get_buf(1'b0, 14'h103);
        check({16'h0, i_mem.mem[10'h240][15:0]}, 32'h103);
        finish(STS_PARTIAL, 14'h102, 10'h5A, 1'b0);
        @(posedge clk);
        buf_req <= 1'b1;
        pkt_start <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end
            while (queue_error_interrupt !== 1'b1 && n < LIM);
        check(queue_error_interrupt, 1'b1);
        if (n >= LIM) final_report();
        i_mem.mem[10'h56] = 32'h202;
        wr(ADDR_LFQ_WRITE, 32'h17);
        wait_buf(14'h202);
        wr(ADDR_ERR_CLEAR, 32'h1);
        @(negedge clk);
        check(queue_error_interrupt, 1'b0);
        finish(STS_GOOD, 14'h202, 10'h5B, 1'b0);
        i_mem.mem[10'h53] = 32'h104;
        wr(ADDR_SFQ_WRITE, 32'h14);
        ack_delay <= 4'h0;
        get_buf(1'b1, 14'h104);
        finish(STS_GOOD, 14'h104, 10'h5C, 1'b1);
        rd_chk(ADDR_RQ_WRITE, 32'h19);
        wr(ADDR_LFQ_WRITE, 32'h18);
        rd_chk(ADDR_STATUS, 32'h50);
        wr(ADDR_LFQ_END, 32'h15);
        rd_chk(ADDR_STATUS, 32'h70);
        final_report();
    end
endmodule

bind rdqm_top rdqm_chk i_chk (.clk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .buf_req, .buf_ack, .pkt_done, .pkt_done_ack, .mem_req,
    .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_ack, .queue_error_interrupt);
`default_nettype wire
